// ---- hdl/afr_config_regs.sv ----
// Configuration, fault status and auxiliary pin register bank of the analog front end
//
// Functional notes
// - Test source bit: 0 external test signals, 1 internal; resets to 0.
// - Test amplitude bit: 0 one unit of reference/2400, 1 two units.
// - Test frequency: 00 clock/2^21, 01 clock/2^20, 11 dc, 10 unused.
// - High reference bit: 0 gives 2.4 V, 1 gives 4 V; resets to 1.
// - Op-amp reference bit: 0 dedicated pin, 1 mid-supply; resets to 0.
// - Op-amp power bit: 0 powered down, 1 enabled; resets to 0.
// - Reference register bit 0 is read-only with undefined value.
// - Three-bit threshold code selects comparator levels, 95/5 percent down to 70/30.
// - Eight channel registers at 05h to 0Ch, channel order, reset 10h.
// - Channel bit 7: 0 normal operation, 1 channel power-down; resets 0.
// - Channel gain code 001,010,100,101,110 for gains 1,2,4,8,12.
// - Channel input select: normal, mid-supply short, supply, temperature, test signal.
// - Positive fault flags, bit n-1 for channel n, set when over threshold.
// - Negative fault flags, bit n-1 for channel n, set when over threshold.
// - Reading pin data returns the real pin levels in either direction.
// - Writing pin data sets output pins only; input pins are unaffected.
// - Pin direction nibble: 0 output, 1 input; resets to all inputs.
// - Rate code 111 unused; rates scale with the actual master clock.
// - Register read command: start address, count minus one, data follows.
// - Register write command: start address, count minus one, data MSB first.
`timescale 1ns/1ps
module afr_config_regs
    import afr_pkg::*;
#(
    parameter int TEST_DIV_LOG2 = AFR_TEST_DIV_LOG2
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic REG_WR_EN,
    input wire logic REG_RD_EN,
    input wire logic [4:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic [AFR_NUM_CHAN-1:0] CHAN_POS_OVER_THRESHOLD,
    input wire logic [AFR_NUM_CHAN-1:0] CHAN_NEG_OVER_THRESHOLD,
    input wire logic [AFR_NUM_PINS-1:0] AUX_PIN_IN,
    output logic [AFR_NUM_PINS-1:0] AUX_PIN_OUT,
    output logic [AFR_NUM_PINS-1:0] AUX_PIN_OE,
    output logic TEST_INTERNAL,
    output logic TEST_AMP_DOUBLE,
    output logic [1:0] TEST_FREQUENCY_SELECT,
    output logic TEST_PULSE,
    output logic HIGH_REFERENCE_SELECT,
    output logic OPAMP_NONINV_SELECT,
    output logic OPAMP_POWER_ENABLE,
    output logic [2:0] FAULT_THRESHOLD_CODE,
    output logic [AFR_NUM_CHAN-1:0] CHANNEL_POWER_DOWN,
    output logic [3*AFR_NUM_CHAN-1:0] CHANNEL_GAIN_CODE,
    output logic [3*AFR_NUM_CHAN-1:0] CHANNEL_INPUT_SELECT
);
    logic [7:0] test_cfg_q;
    logic [7:0] ref_cfg_q;
    logic [7:0] fault_ctl_q;
    logic [7:0] chan_q [AFR_NUM_CHAN];
    logic [3:0] pin_dir_q;
    logic [3:0] pin_out_q;
    logic [3:0] pin_out_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [TEST_DIV_LOG2-1:0] test_cnt_q;
    logic [AFR_NUM_CHAN-1:0] pos_meta_q;
    logic [AFR_NUM_CHAN-1:0] pos_sync_q;
    logic [AFR_NUM_CHAN-1:0] neg_meta_q;
    logic [AFR_NUM_CHAN-1:0] neg_sync_q;
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;

    wire wr = CE && REG_WR_EN;
    wire wr_test = wr && (REG_ADDR == AFR_ADDR_TEST_CFG);
    wire wr_ref = wr && (REG_ADDR == AFR_ADDR_REF_CFG);
    wire wr_fault = wr && (REG_ADDR == AFR_ADDR_FAULT_CTL);
    wire wr_pin = wr && (REG_ADDR == AFR_ADDR_PIN_CTL);
    wire chan_hit = (REG_ADDR >= AFR_ADDR_CHAN_FIRST) && (REG_ADDR <= AFR_ADDR_CHAN_LAST);
    wire [4:0] chan_off = REG_ADDR - AFR_ADDR_CHAN_FIRST;
    wire [2:0] chan_idx = chan_off[2:0];
    wire [3:0] new_dir = REG_WDATA[AFR_PIN_DIR_LSB +: 4];

    // Fault comparators and pins are asynchronous to the register clock
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pos_meta_q <= '0;
            pos_sync_q <= '0;
            neg_meta_q <= '0;
            neg_sync_q <= '0;
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else if (CE) begin
            pos_meta_q <= CHAN_POS_OVER_THRESHOLD;
            pos_sync_q <= pos_meta_q;
            neg_meta_q <= CHAN_NEG_OVER_THRESHOLD;
            neg_sync_q <= neg_meta_q;
            pin_meta_q <= AUX_PIN_IN;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Reserved bits are not stored, so stray host values never reach the analog side
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            test_cfg_q <= AFR_TEST_CFG_RST & AFR_TEST_CFG_WMASK;
            ref_cfg_q <= AFR_REF_CFG_RST & AFR_REF_CFG_WMASK;
            fault_ctl_q <= AFR_FAULT_RST & AFR_FAULT_WMASK;
        end else begin
            if (wr_test) begin
                test_cfg_q <= REG_WDATA & AFR_TEST_CFG_WMASK;
            end
            if (wr_ref) begin
                ref_cfg_q <= REG_WDATA & AFR_REF_CFG_WMASK;
            end
            if (wr_fault) begin
                fault_ctl_q <= REG_WDATA & AFR_FAULT_WMASK;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < AFR_NUM_CHAN; gi++) begin : g_chan
            wire wr_chan = wr && chan_hit && (chan_idx == 3'(gi));
            always_ff @(posedge REF_CLK) begin
                if (RESET) begin
                    chan_q[gi] <= AFR_CHAN_RST;
                end else if (wr_chan) begin
                    chan_q[gi] <= REG_WDATA & AFR_CHAN_WMASK;
                end
            end
            assign CHANNEL_POWER_DOWN[gi] = chan_q[gi][AFR_CH_PD_BIT];
            assign CHANNEL_GAIN_CODE[3*gi +: 3] = chan_q[gi][AFR_CH_GAIN_LSB +: 3];
            assign CHANNEL_INPUT_SELECT[3*gi +: 3] = chan_q[gi][AFR_CH_MUX_LSB +: 3];
        end
    endgenerate

    // Data bits of pins that end up as inputs keep their old output latch value
    assign pin_out_d = (pin_out_q & new_dir) | (REG_WDATA[AFR_PIN_DATA_LSB +: 4] & ~new_dir);

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pin_dir_q <= AFR_PIN_RST[AFR_PIN_DIR_LSB +: 4];
            pin_out_q <= AFR_PIN_RST[AFR_PIN_DATA_LSB +: 4];
        end else if (wr_pin) begin
            pin_dir_q <= new_dir;
            pin_out_q <= pin_out_d;
        end
    end

    // Free-running divider on the master clock, so test rates follow its actual frequency
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            test_cnt_q <= '0;
        end else if (CE) begin
            test_cnt_q <= test_cnt_q + 1'b1;
        end
    end

    wire [1:0] freq_sel = test_cfg_q[AFR_TEST_FREQ_LSB +: 2];
    wire test_pulse_w = (freq_sel == AFR_FREQ_SLOW) ? test_cnt_q[TEST_DIV_LOG2-1] :
                        (freq_sel == AFR_FREQ_FAST) ? test_cnt_q[TEST_DIV_LOG2-2] :
                        (freq_sel == AFR_FREQ_DC);

    // Bit 0 of the reference register is read-only and reads as zero here
    wire [7:0] chan_rd = chan_q[chan_idx];
    always_comb begin
        rdata_d = 8'h00;
        if (REG_ADDR == AFR_ADDR_TEST_CFG) begin
            rdata_d = test_cfg_q | AFR_TEST_CFG_ONES;
        end else if (REG_ADDR == AFR_ADDR_REF_CFG) begin
            rdata_d = ref_cfg_q | AFR_REF_CFG_ONES;
        end else if (REG_ADDR == AFR_ADDR_FAULT_CTL) begin
            rdata_d = fault_ctl_q;
        end else if (chan_hit) begin
            rdata_d = chan_rd;
        end else if (REG_ADDR == AFR_ADDR_POS_FLAGS) begin
            rdata_d = pos_sync_q;
        end else if (REG_ADDR == AFR_ADDR_NEG_FLAGS) begin
            rdata_d = neg_sync_q;
        end else if (REG_ADDR == AFR_ADDR_PIN_CTL) begin
            rdata_d = {pin_sync_q, pin_dir_q};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rdata_q <= 8'h00;
        end else if (CE && REG_RD_EN) begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign AUX_PIN_OUT = pin_out_q;
    assign AUX_PIN_OE = ~pin_dir_q;
    assign TEST_INTERNAL = test_cfg_q[AFR_TEST_SRC_BIT];
    assign TEST_AMP_DOUBLE = test_cfg_q[AFR_TEST_AMP_BIT];
    assign TEST_FREQUENCY_SELECT = freq_sel;
    assign TEST_PULSE = test_pulse_w;
    assign HIGH_REFERENCE_SELECT = ref_cfg_q[AFR_HIREF_BIT];
    assign OPAMP_NONINV_SELECT = ref_cfg_q[AFR_OPREF_BIT];
    assign OPAMP_POWER_ENABLE = ref_cfg_q[AFR_OPPWR_BIT];
    assign FAULT_THRESHOLD_CODE = fault_ctl_q[AFR_THR_LSB +: 3];

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    property p_test_src;
        wr_test |=> TEST_INTERNAL == $past(REG_WDATA[4]) && TEST_AMP_DOUBLE == $past(REG_WDATA[2]);
    endproperty
    a_test_src: assert property (p_test_src) else $error("test source or amplitude not updated");

    property p_freq_dc;
        TEST_FREQUENCY_SELECT == 2'h3 |-> TEST_PULSE;
    endproperty
    a_freq_dc: assert property (p_freq_dc) else $error("dc test level not high");

    property p_freq_unused;
        TEST_FREQUENCY_SELECT == 2'h2 |-> !TEST_PULSE;
    endproperty
    a_freq_unused: assert property (p_freq_unused) else $error("unused code drives pulse");

    // Looks one edge ahead so the unreset state before the first edge is never judged
    property p_ref_reset;
        RESET |=> HIGH_REFERENCE_SELECT && !OPAMP_POWER_ENABLE && !OPAMP_NONINV_SELECT;
    endproperty
    a_ref_reset: assert property (disable iff (1'b0) p_ref_reset) else $error("bad reference reset");

    property p_reserved_ones;
        CE && REG_RD_EN && REG_ADDR == 5'h02 |=> REG_RDATA[7:5] == 3'h7 && !REG_RDATA[3];
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved bits read wrong");

    property p_ref_bit0;
        CE && REG_RD_EN && REG_ADDR == 5'h03 |=> REG_RDATA[7:6] == 2'h3 && REG_RDATA[1:0] == 2'h0;
    endproperty
    a_ref_bit0: assert property (p_ref_bit0) else $error("reference register readback wrong");

    property p_chan_write;
        wr && REG_ADDR == 5'h07 |=> CHANNEL_POWER_DOWN[2] == $past(REG_WDATA[7])
            && CHANNEL_INPUT_SELECT[8:6] == $past(REG_WDATA[2:0]);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel 3 not updated");

    property p_pos_flags;
        CE && REG_RD_EN && REG_ADDR == 5'h12 |=> REG_RDATA == $past(pos_sync_q);
    endproperty
    a_pos_flags: assert property (p_pos_flags) else $error("positive flags readback wrong");

    property p_pin_read;
        CE && REG_RD_EN && REG_ADDR == 5'h14 |=> REG_RDATA[7:4] == $past(pin_sync_q);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin levels readback wrong");

    property p_pin_input_hold;
        wr_pin && REG_WDATA[0] |=> AUX_PIN_OUT[0] == $past(AUX_PIN_OUT[0]);
    endproperty
    a_pin_input_hold: assert property (p_pin_input_hold) else $error("input pin latch changed");

    property p_pin_dir;
        wr_pin |=> AUX_PIN_OE == ~$past(REG_WDATA[3:0]);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin enable mismatches direction");

    property p_status_ro;
        wr && (REG_ADDR == 5'h12 || REG_ADDR == 5'h13) |=> $stable(CHANNEL_POWER_DOWN)
            && $stable(FAULT_THRESHOLD_CODE) && $stable(AUX_PIN_OE);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed state");

    property p_opref_write;
        wr_ref |=> OPAMP_NONINV_SELECT == $past(REG_WDATA[3])
            && HIGH_REFERENCE_SELECT == $past(REG_WDATA[5]);
    endproperty
    a_opref_write: assert property (p_opref_write) else $error("op-amp reference not updated");

    property p_oppwr_write;
        wr_ref |=> OPAMP_POWER_ENABLE == $past(REG_WDATA[2]);
    endproperty
    a_oppwr_write: assert property (p_oppwr_write) else $error("op-amp power not updated");

    property p_threshold_write;
        wr_fault |=> FAULT_THRESHOLD_CODE == $past(REG_WDATA[7:5]);
    endproperty
    a_threshold_write: assert property (p_threshold_write) else $error("threshold not updated");

    property p_gain_write;
        wr && REG_ADDR == 5'h0c |=> CHANNEL_GAIN_CODE[23:21] == $past(REG_WDATA[6:4]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("channel 8 gain not updated");

    property p_neg_flags;
        CE && REG_RD_EN && REG_ADDR == 5'h13 |=> REG_RDATA == $past(neg_sync_q);
    endproperty
    a_neg_flags: assert property (p_neg_flags) else $error("negative flags readback wrong");

    // Holes in the map read as zero, so a burst read across them stays predictable
    property p_gap_read;
        CE && REG_RD_EN && REG_ADDR == 5'h0d |=> REG_RDATA == 8'h00;
    endproperty
    a_gap_read: assert property (p_gap_read) else $error("unmapped address read not zero");

    c_pin_write: cover property (wr_pin && REG_WDATA[3:0] == 4'h0);
    c_chan_read: cover property (CE && REG_RD_EN && chan_hit);
    c_test_dc: cover property (wr_test && REG_WDATA[1:0] == 2'h3 ##1 TEST_PULSE);
    c_frozen_write: cover property (!CE && REG_WR_EN);
endmodule : afr_config_regs

// ---- hdl/afr_pkg.sv ----
// Package with the register map, field layout and reset values of the configuration bank
package afr_pkg;
    // Register addresses (five-bit register address space)
    localparam logic [4:0] AFR_ADDR_TEST_CFG = 5'h02;
    localparam logic [4:0] AFR_ADDR_REF_CFG = 5'h03;
    localparam logic [4:0] AFR_ADDR_FAULT_CTL = 5'h04;
    localparam logic [4:0] AFR_ADDR_CHAN_FIRST = 5'h05;
    localparam logic [4:0] AFR_ADDR_CHAN_LAST = 5'h0c;
    localparam logic [4:0] AFR_ADDR_POS_FLAGS = 5'h12;
    localparam logic [4:0] AFR_ADDR_NEG_FLAGS = 5'h13;
    localparam logic [4:0] AFR_ADDR_PIN_CTL = 5'h14;

    localparam int AFR_NUM_CHAN = 8;
    localparam int AFR_NUM_PINS = 4;

    // Field positions
    localparam int AFR_TEST_SRC_BIT = 4;
    localparam int AFR_TEST_AMP_BIT = 2;
    localparam int AFR_TEST_FREQ_LSB = 0;
    localparam int AFR_HIREF_BIT = 5;
    localparam int AFR_OPREF_BIT = 3;
    localparam int AFR_OPPWR_BIT = 2;
    localparam int AFR_THR_LSB = 5;
    localparam int AFR_CH_PD_BIT = 7;
    localparam int AFR_CH_GAIN_LSB = 4;
    localparam int AFR_CH_MUX_LSB = 0;
    localparam int AFR_PIN_DATA_LSB = 4;
    localparam int AFR_PIN_DIR_LSB = 0;

    // Storage masks: only these bits hold state, the rest are fixed on readback
    localparam logic [7:0] AFR_TEST_CFG_WMASK = 8'h17;
    localparam logic [7:0] AFR_REF_CFG_WMASK = 8'h2c;
    localparam logic [7:0] AFR_FAULT_WMASK = 8'he0;
    localparam logic [7:0] AFR_CHAN_WMASK = 8'hf7;
    // Reserved bits that always read as one
    localparam logic [7:0] AFR_TEST_CFG_ONES = 8'he0;
    localparam logic [7:0] AFR_REF_CFG_ONES = 8'hc0;

    // Reset values as seen on readback
    localparam logic [7:0] AFR_TEST_CFG_RST = 8'he0;
    localparam logic [7:0] AFR_REF_CFG_RST = 8'he0;
    localparam logic [7:0] AFR_FAULT_RST = 8'h00;
    localparam logic [7:0] AFR_CHAN_RST = 8'h10;
    localparam logic [7:0] AFR_PIN_RST = 8'h0f;

    // Test frequency codes
    localparam logic [1:0] AFR_FREQ_SLOW = 2'h0;
    localparam logic [1:0] AFR_FREQ_FAST = 2'h1;
    localparam logic [1:0] AFR_FREQ_UNUSED = 2'h2;
    localparam logic [1:0] AFR_FREQ_DC = 2'h3;

    // Slow test pulse period is the master clock divided by two to this power
    localparam int AFR_TEST_DIV_LOG2 = 21;
endpackage : afr_pkg

// ---- testbench/afr_host_model.sv ----
// Host side model: one register strobe per serial command data byte
`timescale 1ns/1ps
module afr_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr_en,
    output logic rd_en,
    output logic [4:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
    end

    // Released lines flip so a stale value can never look valid
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : wr

    task rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        d = rdata;
        rd_en = 1'b0;
        addr = ~a;
    endtask : rd
endmodule : afr_host_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench
    import afr_pkg::*;
;
    typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} afr_row_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic wr_en, rd_en, ti, ta, tp, hr, on, op;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, pd;
    logic [7:0] pf = 8'h00;
    logic [7:0] nf = 8'h00;
    logic [3:0] ext = 4'h0;
    logic [3:0] pout, poe, pin;
    logic [1:0] tf;
    logic [2:0] thr;
    logic [23:0] gc, sel;
    int fails = 0;
    int n_checks = 0;
    int n;
    logic tp_prev;
    int tog[4] = '{8, 16, 0, 0};
    afr_row_t rows[10] = '{
        '{5'h02, 8'hff, 8'hf7}, '{5'h02, 8'h00, 8'he0}, '{5'h03, 8'hff, 8'hec},
        '{5'h03, 8'h00, 8'hc0}, '{5'h04, 8'hff, 8'he0}, '{5'h04, 8'h1f, 8'h00},
        '{5'h05, 8'hff, 8'hf7}, '{5'h0c, 8'h83, 8'h83}, '{5'h0d, 8'hff, 8'h00},
        '{5'h1f, 8'haa, 8'h00}};

    // Pins driven by the block win over the external source
    assign pin = (poe & pout) | (~poe & ext);

    afr_config_regs #(.TEST_DIV_LOG2(4)) dut (
        .REF_CLK(ref_clk), .RESET(reset), .CE(ce), .REG_WR_EN(wr_en),
        .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CHAN_POS_OVER_THRESHOLD(pf), .CHAN_NEG_OVER_THRESHOLD(nf),
        .AUX_PIN_IN(pin), .AUX_PIN_OUT(pout), .AUX_PIN_OE(poe),
        .TEST_INTERNAL(ti), .TEST_AMP_DOUBLE(ta), .TEST_FREQUENCY_SELECT(tf),
        .TEST_PULSE(tp), .HIGH_REFERENCE_SELECT(hr), .OPAMP_NONINV_SELECT(on),
        .OPAMP_POWER_ENABLE(op), .FAULT_THRESHOLD_CODE(thr), .CHANNEL_POWER_DOWN(pd),
        .CHANNEL_GAIN_CODE(gc), .CHANNEL_INPUT_SELECT(sel));

    afr_host_model host (.clk(ref_clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task cmp_vec(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_vec

    task cmp_cnt(input string nm, input int e, input int g);
        n_checks++;
        if (g != e) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_cnt

    // Bit 0 of the reference register is undefined, so callers mask it
    task rd_cmp(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        host.rd(a, d);
        cmp_vec("readback", 24'(e & m), 24'(d & m));
    endtask : rd_cmp

    task summarize;
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        rd_cmp(5'h02, 8'he0, 8'hff);
        rd_cmp(5'h03, 8'he0, 8'hfe);
        rd_cmp(5'h04, 8'h00, 8'hff);
        rd_cmp(5'h12, 8'h00, 8'hff);
        rd_cmp(5'h13, 8'h00, 8'hff);
        rd_cmp(5'h14, 8'h0f, 8'hff);
        for (int i = 0; i < 8; i++) rd_cmp(5'(5 + i), 8'h10, 8'hff);
        cmp_vec("ref_ports", 24'h4, 24'({hr, on, op}));
        cmp_vec("pin_oe", 24'h0, 24'(poe));
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            rd_cmp(rows[i].a, rows[i].e, 8'hfe);
        end
        host.wr(5'h02, 8'h17);
        cmp_vec("test_ports", 24'hf, 24'({ti, ta, tf}));
        host.wr(5'h03, 8'h0c);
        cmp_vec("ref_ports", 24'h3, 24'({hr, on, op}));
        host.wr(5'h04, 8'ha0);
        cmp_vec("threshold", 24'h5, 24'(thr));
        for (int i = 0; i < 8; i++) host.wr(5'(5 + i), {i[0], i[2:0], 1'b0, 3'(7 - i)});
        for (int i = 0; i < 8; i++) begin
            cmp_vec("power_down", 24'(i[0]), 24'(pd[i]));
            cmp_vec("gain", 24'(i[2:0]), 24'(gc[3*i+:3]));
            cmp_vec("input_sel", 24'(7 - i), 24'(sel[3*i+:3]));
        end
        for (int f = 0; f < 4; f++) begin
            host.wr(5'h02, 8'(f));
            cmp_vec("freq_sel", 24'(f), 24'(tf));
            n = 0;
            tp_prev = tp;
            repeat (64) begin
                @(negedge ref_clk);
                if (tp !== dut.TEST_PULSE) n++;
                if (tp_prev !== tp) n++;
                tp_prev = tp;
            end
            cmp_cnt("toggles", tog[f], n);
            if (f > 1) cmp_vec("dc_level", 24'(f - 2), 24'(tp));
        end
        pf = 8'ha5;
        nf = 8'h3c;
        repeat (3) @(negedge ref_clk);
        rd_cmp(5'h12, 8'ha5, 8'hff);
        rd_cmp(5'h13, 8'h3c, 8'hff);
        host.wr(5'h12, 8'h00);
        host.wr(5'h13, 8'hff);
        rd_cmp(5'h12, 8'ha5, 8'hff);
        rd_cmp(5'h13, 8'h3c, 8'hff);
        ext = 4'b1101;
        host.wr(5'h14, 8'ha3);
        cmp_vec("pin_drive", 24'hc8, 24'({poe, pout & poe}));
        repeat (3) @(negedge ref_clk);
        rd_cmp(5'h14, 8'h93, 8'hff);
        host.wr(5'h14, 8'h5f);
        cmp_vec("pin_drive", 24'h08, 24'({poe, pout}));
        repeat (3) @(negedge ref_clk);
        rd_cmp(5'h14, 8'hdf, 8'hff);
        ce = 1'b0;
        host.wr(5'h04, 8'h60);
        ce = 1'b1;
        cmp_vec("threshold", 24'h5, 24'(thr));
        @(negedge ref_clk);
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        cmp_vec("ref_ports", 24'h4, 24'({hr, on, op}));
        rd_cmp(5'h07, 8'h10, 8'hff);
        summarize();
    end
endmodule : testbench
